/* File: flash_cfg.svh */
// constants for the flash sector protection and reset control block
// assumes a 200 MHz ref_clk and a 12-bit flash command address
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ             200
`define ABORT_TIME_US       25
`define SMALL_RESET_TIME_MS 2
`define ABORT_CYCLES        (`ABORT_TIME_US * `CLK_MHZ)
`define SMALL_RESET_CYCLES  (`SMALL_RESET_TIME_MS * 1000 * `CLK_MHZ)
`define PROT_SETTLE_CYCLES  3'h4

// ****************************************************************
// command cycles
// ****************************************************************
`define UNLOCK1_ADDR        12'h555
`define UNLOCK1_DATA        8'haa
`define UNLOCK2_ADDR        12'haaa
`define UNLOCK2_DATA        8'h55
`define RESET_CMD_DATA      8'hf0

// ****************************************************************
// lock status registers in control register space
// ****************************************************************
`define MAIN_LOCK_OFFSET    8'hc0
`define SEC_LOCK_OFFSET     8'hc2
`define MAIN_SECTORS        8
`define SEC_SECTORS         4
`define SECURITY_BIT_POS    7
`define LOCK_REG_RESET      8'h00

`endif

/* File: flash_pkg.sv */
// types shared by the flash sector protection and reset control block
// assumes nothing beyond a SystemVerilog compiler
package flash_pkg;

  // ****************************************************************
  // flash operating mode
  // ****************************************************************
  typedef enum logic [2:0]
  {
    FL_READ    = 3'b000,
    FL_PROGRAM = 3'b001,
    FL_BULK    = 3'b010,
    FL_SECTOR  = 3'b011,
    FL_RECOVER = 3'b100
  } flash_mode_t;

  // ****************************************************************
  // unlock prefix progress
  // ****************************************************************
  typedef enum logic [1:0]
  {
    UNL_NONE   = 2'b00,
    UNL_FIRST  = 2'b01,
    UNL_SECOND = 2'b10
  } unlock_step_t;

endpackage : flash_pkg

/* File: pin_sync3.sv */
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to ref_clk; output is a flip-flop
`timescale 1ns/1ps
module pin_sync3
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;

  // bits whose second and third stages agree
  assign agree = ~(stage2_reg ^ stage3_reg);

  // shift chain; first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // output moves only once two stages agree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sync_out <= '0;
    else
      sync_out <= (stage2_reg & agree) | (sync_out & ~agree);
  end

endmodule : pin_sync3

/* File: flash_sector_protect_and_reset.sv */
// flash sector protection gate, lock status registers and reset control
// assumes a command sequencer raising one-cycle operation requests
`timescale 1ns/1ps
`include "flash_cfg.svh"

module flash_sector_protect_and_reset
#(
  parameter bit       LARGE_VARIANT  = 1'b1,
  parameter int       ABORT_CYCLES   = `ABORT_CYCLES,
  parameter int       SMALL_CYCLES   = `SMALL_RESET_CYCLES,
  parameter bit [7:0] RESET_CMD      = `RESET_CMD_DATA
)
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   bus_wr_strobe,
  input  wire logic                   bus_rd_strobe,
  input  wire logic [11:0]            bus_addr,
  input  wire logic [7:0]             bus_wdata,
  input  wire logic                   control_register_space,
  input  wire logic [7:0]             main_sector_select,
  input  wire logic [3:0]             secondary_sector_select,
  input  wire logic [7:0]             array_rdata,
  input  wire logic                   prog_req,
  input  wire logic                   sector_erase_req,
  input  wire logic                   bulk_erase_req,
  input  wire logic                   algo_done,
  input  wire logic                   algo_timeout,
  input  wire logic                   algo_bit_fault,
  input  wire logic [7:0]             main_lock_nv,
  input  wire logic [3:0]             sec_lock_nv,
  input  wire logic                   security_lock_nv,
  input  wire logic                   reset_pin_n,
  input  wire logic                   sram_select,
  input  wire logic                   battery_ind_enable,
  input  wire logic                   supply_below_battery,
  output logic [7:0]                  bus_rdata,
  output logic                        array_write_grant,
  output logic [11:0]                 erase_sector_mask,
  output flash_pkg::flash_mode_t      flash_mode,
  output logic                        read_mode,
  output logic                        error_status_bit,
  output logic                        sram_enable,
  output logic                        battery_active
);
  import flash_pkg::*;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [12:0] lock_sync;
  logic [1:0]  pin_sync;
  logic [7:0]  main_lock;
  logic [3:0]  sec_lock;
  logic        security_lock;
  logic        reset_pin_act;
  logic        supply_low;
  logic        pin_act_d_reg;
  logic [2:0]  settle_reg;

  // nonvolatile lock bits arrive from the configuration cells
  pin_sync3 #(.WIDTH(13)) u_lock_sync
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({security_lock_nv, sec_lock_nv, main_lock_nv}),
    .sync_out (lock_sync)
  );

  // reset pin and supply comparator
  pin_sync3 #(.WIDTH(2)) u_pin_sync
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({~reset_pin_n, supply_below_battery}),
    .sync_out (pin_sync)
  );

  assign main_lock     = lock_sync[7:0];
  assign sec_lock      = lock_sync[11:8];
  assign security_lock = lock_sync[12];
  assign reset_pin_act = pin_sync[1];
  assign supply_low    = pin_sync[0];

  // lock bits untrusted until the synchroniser has filled
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      settle_reg <= 3'h0;
    else if (settle_reg != `PROT_SETTLE_CYCLES)
      settle_reg <= settle_reg + 3'h1;
  end

  // falling edge of reset_pin_n (reset asserted), taken from the filtered level
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_act_d_reg <= 1'b0;
    else
      pin_act_d_reg <= reset_pin_act;
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  unlock_step_t unlock_reg;
  unlock_step_t unlock_next;
  logic         flash_sel;
  logic         flash_wr;
  logic         reset_cmd;
  logic         pin_abort;
  logic         prot_ready;
  logic         target_locked;
  logic         busy;

  assign flash_sel  = (|main_sector_select) | (|secondary_sector_select);
  assign flash_wr   = bus_wr_strobe & ~control_register_space & flash_sel;
  // plain or unlocked reset; a lone first unlock breaks the prefix
  assign reset_cmd  = flash_wr & (bus_wdata == RESET_CMD)
                    & (unlock_reg != UNL_FIRST);
  assign pin_abort  = LARGE_VARIANT & reset_pin_act & ~pin_act_d_reg;
  assign prot_ready = (settle_reg == `PROT_SETTLE_CYCLES);
  assign busy       = (flash_mode == FL_PROGRAM) | (flash_mode == FL_BULK)
                    | (flash_mode == FL_SECTOR);

  // secondary sector wins where both selects overlap
  assign target_locked = (|secondary_sector_select)
                       ? |(secondary_sector_select & sec_lock)
                       : |(main_sector_select & main_lock);

  // unlock prefix tracking
  always_comb
  begin
    unlock_next = UNL_NONE;
    if (bus_addr == `UNLOCK1_ADDR && bus_wdata == `UNLOCK1_DATA)
      unlock_next = UNL_FIRST;
    else if (unlock_reg == UNL_FIRST && bus_addr == `UNLOCK2_ADDR
             && bus_wdata == `UNLOCK2_DATA)
      unlock_next = UNL_SECOND;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      unlock_reg <= UNL_NONE;
    else if (flash_wr)
      unlock_reg <= unlock_next;
  end

  // ****************************************************************
  // operation gate and mode sequencing
  // ****************************************************************
  logic [31:0] recover_cnt_reg;

  // requests to locked sectors never reach the array
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      array_write_grant <= 1'b0;
      erase_sector_mask <= 12'h000;
    end
    else
    begin
      array_write_grant <= 1'b0;
      if (flash_mode == FL_READ && prot_ready && !pin_abort)
      begin
        if ((prog_req || sector_erase_req) && !target_locked)
        begin
          array_write_grant <= 1'b1;
          erase_sector_mask <= sector_erase_req
            ? {secondary_sector_select & ~sec_lock,
               main_sector_select & ~main_lock}
            : 12'h000;
        end
        else if (bulk_erase_req)
        begin
          array_write_grant <= 1'b1;
          erase_sector_mask <= {~sec_lock, ~main_lock};
        end
      end
    end
  end

  // mode machine with recovery countdown
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flash_mode      <= FL_READ;
      recover_cnt_reg <= 32'h0;
    end
    else if (pin_abort)
    begin
      if (busy)
      begin
        flash_mode      <= FL_RECOVER;
        recover_cnt_reg <= 32'(ABORT_CYCLES - 1);
      end
      else
        flash_mode <= FL_READ;
    end
    else
    begin
      unique case (flash_mode)
        FL_READ:
        begin
          if (reset_cmd && !LARGE_VARIANT)
          begin
            flash_mode      <= FL_RECOVER;
            recover_cnt_reg <= 32'(SMALL_CYCLES - 1);
          end
          else if (reset_cmd && error_status_bit)
          begin
            flash_mode      <= FL_RECOVER;
            recover_cnt_reg <= 32'(ABORT_CYCLES - 1);
          end
          else if (prot_ready && (prog_req || sector_erase_req)
                   && !target_locked)
            flash_mode <= prog_req ? FL_PROGRAM : FL_SECTOR;
          else if (prot_ready && bulk_erase_req)
            flash_mode <= FL_BULK;
        end
        FL_PROGRAM, FL_BULK:
        begin
          if (algo_done)
            flash_mode <= FL_READ;
        end
        FL_SECTOR:
        begin
          if (reset_cmd)
          begin
            flash_mode      <= FL_RECOVER;
            recover_cnt_reg <= LARGE_VARIANT
                             ? 32'(ABORT_CYCLES - 1)
                             : 32'(SMALL_CYCLES - 1);
          end
          else if (algo_done)
            flash_mode <= FL_READ;
        end
        FL_RECOVER:
        begin
          if (recover_cnt_reg == 32'h0)
            flash_mode <= FL_READ;
          else
            recover_cnt_reg <= recover_cnt_reg - 32'h1;
        end
        default:
          flash_mode <= FL_READ;
      endcase
    end
  end

  // read mode indicator
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      read_mode <= 1'b1;
    else
      read_mode <= (flash_mode == FL_READ);
  end

  // ****************************************************************
  // error status bit
  // ****************************************************************
  logic err_set;
  logic err_clr;

  assign err_set = busy & (algo_timeout | algo_bit_fault);
  assign err_clr = (flash_mode == FL_RECOVER && recover_cnt_reg == 32'h0)
                 | pin_abort;

  // a fault in the clearing cycle is kept
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      error_status_bit <= 1'b0;
    else if (err_set)
      error_status_bit <= 1'b1;
    else if (err_clr)
      error_status_bit <= 1'b0;
  end

  // ****************************************************************
  // read data: lock status registers or array data
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bus_rdata <= `LOCK_REG_RESET;
    else if (bus_rd_strobe && control_register_space)
    begin
      if (bus_addr[7:0] == `MAIN_LOCK_OFFSET)
        bus_rdata <= main_lock;
      else if (bus_addr[7:0] == `SEC_LOCK_OFFSET)
        bus_rdata <= {security_lock, 3'h0, sec_lock};
      else
        bus_rdata <= 8'h00;
    end
    else if (bus_rd_strobe)
      bus_rdata <= array_rdata;
  end

  // ****************************************************************
  // sram enable and battery indicator
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sram_enable    <= 1'b0;
      battery_active <= 1'b0;
    end
    else
    begin
      sram_enable    <= sram_select;
      battery_active <= battery_ind_enable & supply_low;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_reset_in_sector;
    reset_cmd && !pin_abort && flash_mode == FL_SECTOR;
  endsequence

  sequence s_recovering;
    (flash_mode == FL_RECOVER) ##1 (flash_mode == FL_RECOVER);
  endsequence

  a_locked_no_grant: assert property (
    (flash_mode == FL_READ && prog_req && target_locked && !bulk_erase_req
     && !reset_cmd)
    |=> !array_write_grant && flash_mode == FL_READ)
    else $error("write granted to a locked sector");

  a_busy_reset_ignored: assert property (
    (reset_cmd && !pin_abort && !algo_done
     && (flash_mode == FL_PROGRAM || flash_mode == FL_BULK))
    |=> flash_mode == $past(flash_mode))
    else $error("reset command not ignored while busy");

  a_sector_abort_seq: assert property (
    s_reset_in_sector |=> s_recovering)
    else $error("sector erase not aborted by reset command");

  a_recover_bound: assert property (
    (LARGE_VARIANT && flash_mode == FL_RECOVER)
    |-> recover_cnt_reg < 32'(ABORT_CYCLES))
    else $error("recovery longer than the abort time");

  a_main_lock_read: assert property (
    (bus_rd_strobe && control_register_space
     && bus_addr[7:0] == `MAIN_LOCK_OFFSET)
    |=> bus_rdata == $past(main_lock))
    else $error("main lock register read wrong");

  a_sec_lock_read: assert property (
    (bus_rd_strobe && control_register_space
     && bus_addr[7:0] == `SEC_LOCK_OFFSET)
    |=> bus_rdata[6:4] == 3'h0
        && bus_rdata[`SECURITY_BIT_POS] == $past(security_lock)
        && bus_rdata[3:0] == $past(sec_lock))
    else $error("secondary lock register read wrong");

  a_verify_read: assert property (
    (bus_rd_strobe && !control_register_space)
    |=> bus_rdata == $past(array_rdata))
    else $error("array read data not returned");

  a_sram_follow: assert property (
    ##1 sram_enable == $past(sram_select))
    else $error("sram enable does not follow its select");

  a_error_sets: assert property (
    err_set |=> error_status_bit)
    else $error("error bit not set on algorithm fault");

  a_reset_at_once: assert property (
    (LARGE_VARIANT && reset_cmd && !pin_abort
     && flash_mode == FL_READ && !error_status_bit)
    |=> flash_mode == FL_READ ##1 read_mode)
    else $error("reset command did not keep read mode");

  a_pin_abort_busy: assert property (
    (pin_abort && busy) |=> flash_mode == FL_RECOVER)
    else $error("reset pin did not abort the operation");

endmodule : flash_sector_protect_and_reset

/* File: mcu_bus_model.sv */
// host bus model: single-byte writes and reads, reset command sequences
// assumes ref_clk from the bench; the bench calls its tasks
`timescale 1ns/1ps
`include "flash_cfg.svh"
module mcu_bus_model
(
  input  wire logic        ref_clk,
  input  wire logic [7:0]  bus_rdata_in,
  output logic             bus_wr_strobe,
  output logic             bus_rd_strobe,
  output logic [11:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  output logic             control_register_space
);
  // bus idle at time zero
  initial
  begin
    bus_wr_strobe = 1'b0;
    bus_rd_strobe = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 8'h00;
    control_register_space = 1'b0;
  end

  // one write cycle; data line no longer holds the value once released
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic c);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    control_register_space <= c;
    bus_wr_strobe <= 1'b1;
    @(posedge ref_clk);
    bus_wr_strobe <= 1'b0;
    bus_wdata <= ~d;
    #1;
  endtask : wr

  // one read cycle; data taken one cycle after the strobe edge
  task automatic rd(input logic [11:0] a, input logic c, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    control_register_space <= c;
    bus_rd_strobe <= 1'b1;
    @(posedge ref_clk);
    bus_rd_strobe <= 1'b0;
    #1;
    d = bus_rdata_in;
  endtask : rd

  // reset command, with or without the two unlock writes
  task automatic rst_cmd(input bit unlock);
    if (unlock)
    begin
      wr(`UNLOCK1_ADDR, `UNLOCK1_DATA, 1'b0);
      wr(`UNLOCK2_ADDR, `UNLOCK2_DATA, 1'b0);
    end
    wr(12'h000, `RESET_CMD_DATA, 1'b0);
  endtask : rst_cmd

endmodule : mcu_bus_model

/* File: flash_sector_protect_and_reset_tb.sv */
// self-checking bench for the sector protection and reset control block
// assumes mcu_bus_model as host; large variant with shortened abort count
`timescale 1ns/1ps
`include "flash_cfg.svh"
module flash_sector_protect_and_reset_tb;
  import flash_pkg::*;
  localparam int ABORT = 8;
  localparam int SMALL = 10;
  logic ref_clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1;
  logic prog_req = 0, sector_erase_req = 0, bulk_erase_req = 0;
  logic algo_done = 0, algo_timeout = 0, algo_bit_fault = 0;
  logic [7:0] main_lock_nv = 0, array_rdata = 0, main_sector_select = 1;
  logic [3:0] sec_lock_nv = 0, secondary_sector_select = 0;
  logic security_lock_nv = 0, sram_select = 0;
  logic battery_ind_enable = 0, supply_below_battery = 0;
  logic bus_wr_strobe, bus_rd_strobe, control_register_space;
  logic [11:0] bus_addr, erase_sector_mask, em = 12'h000;
  logic [7:0] bus_wdata, bus_rdata, ml, d, lf = 8'h2e;
  logic [3:0] sl;
  logic array_write_grant, read_mode, error_status_bit;
  logic sram_enable, battery_active, g;
  flash_mode_t flash_mode, small_mode, m;
  int fail_count = 0, samples_checked = 0, n;
  logic q[$];

  always #2.5 ref_clk = ~ref_clk;

  mcu_bus_model bus (.ref_clk(ref_clk), .bus_wr_strobe(bus_wr_strobe),
    .bus_rd_strobe(bus_rd_strobe), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata_in(bus_rdata),
    .control_register_space(control_register_space));

  flash_sector_protect_and_reset #(.ABORT_CYCLES(ABORT),
    .SMALL_CYCLES(SMALL)) dut (.ref_clk(ref_clk),
    .rst(rst), .bus_wr_strobe(bus_wr_strobe), .bus_rd_strobe(bus_rd_strobe),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .control_register_space(control_register_space),
    .main_sector_select(main_sector_select),
    .secondary_sector_select(secondary_sector_select),
    .array_rdata(array_rdata), .prog_req(prog_req),
    .sector_erase_req(sector_erase_req), .bulk_erase_req(bulk_erase_req),
    .algo_done(algo_done), .algo_timeout(algo_timeout),
    .algo_bit_fault(algo_bit_fault), .main_lock_nv(main_lock_nv),
    .sec_lock_nv(sec_lock_nv), .security_lock_nv(security_lock_nv),
    .reset_pin_n(reset_pin_n), .sram_select(sram_select),
    .battery_ind_enable(battery_ind_enable),
    .supply_below_battery(supply_below_battery), .bus_rdata(bus_rdata),
    .array_write_grant(array_write_grant),
    .erase_sector_mask(erase_sector_mask), .flash_mode(flash_mode),
    .read_mode(read_mode), .error_status_bit(error_status_bit),
    .sram_enable(sram_enable), .battery_active(battery_active));

  // small variant: same stimulus, only its mode is watched
  flash_sector_protect_and_reset #(.LARGE_VARIANT(1'b0),
    .ABORT_CYCLES(ABORT), .SMALL_CYCLES(SMALL)) dut_small
    (.ref_clk(ref_clk), .rst(rst), .bus_wr_strobe(bus_wr_strobe),
    .bus_rd_strobe(bus_rd_strobe), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .control_register_space(control_register_space),
    .main_sector_select(main_sector_select),
    .secondary_sector_select(secondary_sector_select),
    .array_rdata(array_rdata), .prog_req(prog_req),
    .sector_erase_req(sector_erase_req), .bulk_erase_req(bulk_erase_req),
    .algo_done(algo_done), .algo_timeout(algo_timeout),
    .algo_bit_fault(algo_bit_fault), .main_lock_nv(main_lock_nv),
    .sec_lock_nv(sec_lock_nv), .security_lock_nv(security_lock_nv),
    .reset_pin_n(reset_pin_n), .sram_select(sram_select),
    .battery_ind_enable(battery_ind_enable),
    .supply_below_battery(supply_below_battery), .bus_rdata(),
    .array_write_grant(), .erase_sector_mask(), .flash_mode(small_mode),
    .read_mode(), .error_status_bit(), .sram_enable(),
    .battery_active());

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle pulse of {prog, sector, bulk, done, timeout, bit fault}
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk);
    prog_req <= v[5];
    sector_erase_req <= v[4];
    bulk_erase_req <= v[3];
    algo_done <= v[2];
    algo_timeout <= v[1];
    algo_bit_fault <= v[0];
    @(posedge ref_clk);
    prog_req <= 1'b0;
    sector_erase_req <= 1'b0;
    bulk_erase_req <= 1'b0;
    algo_done <= 1'b0;
    algo_timeout <= 1'b0;
    algo_bit_fault <= 1'b0;
    #1;
  endtask : pulse

  task automatic wait_mode(input flash_mode_t m, input int mx);
    n = 0;
    while (flash_mode !== m && n < mx)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_mode

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #100000;
    fail_count++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk({flash_mode, read_mode, error_status_bit}, 5'h02);
    // lock status registers, read-only, unmapped offset
    lf = lfsr(lf);
    ml = lf & 8'hfe;
    sl = lf[7:4] & 4'he;
    @(posedge ref_clk);
    main_lock_nv <= ml;
    sec_lock_nv <= sl;
    security_lock_nv <= lf[2];
    repeat (8) @(posedge ref_clk);
    bus.rd({4'h0, `MAIN_LOCK_OFFSET}, 1'b1, d);
    chk(d, ml);
    bus.rd({4'h0, `SEC_LOCK_OFFSET}, 1'b1, d);
    chk(d, {lf[2], 3'h0, sl});
    bus.wr({4'h0, `MAIN_LOCK_OFFSET}, ~ml, 1'b1);
    bus.rd({4'h0, `MAIN_LOCK_OFFSET}, 1'b1, d);
    chk(d, ml);
    bus.rd(12'h0c4, 1'b1, d);
    chk(d, 8'h00);
    bus.rst_cmd(1'b0);
    chk({flash_mode, small_mode}, {FL_READ, FL_RECOVER});
    repeat (9) @(posedge ref_clk);
    #1;
    chk(small_mode, FL_RECOVER);
    @(posedge ref_clk);
    #1;
    chk(small_mode, FL_READ);
    $display("lock registers done");
    // verify read and per-sector gating of program and sector erase
    for (int i = 0; i < 12; i++)
    begin
      lf = lfsr(lf);
      @(posedge ref_clk);
      array_rdata <= lf;
      main_sector_select <= (i < 8) ? 8'h01 << i : 8'h00;
      secondary_sector_select <= (i < 8) ? 4'h0 : 4'h1 << (i - 8);
      bus.rd(12'h000, 1'b0, d);
      chk(d, lf);
      g = (i < 8) ? !ml[i] : !sl[i-8];
      pulse((i % 2) ? 6'h10 : 6'h20);
      chk(array_write_grant, g);
      if (g)
        em = (i % 2) ? 12'h001 << i : 12'h000;
      m = !g ? FL_READ : (i % 2) ? FL_SECTOR : FL_PROGRAM;
      chk(flash_mode, m);
      chk(erase_sector_mask, em);
      if (g)
        pulse(6'h04);
    end
    main_sector_select <= 8'h01;
    secondary_sector_select <= 4'h0;
    $display("sector gating done");
    // program ignores reset; error then slow recovery
    pulse(6'h20);
    bus.rst_cmd(1'b0);
    chk(flash_mode, FL_PROGRAM);
    pulse(6'h01);
    chk(error_status_bit, 1'b1);
    pulse(6'h04);
    bus.rst_cmd(1'b1);
    chk(flash_mode, FL_RECOVER);
    wait_mode(FL_READ, 40);
    chk({31'(n), error_status_bit}, {31'(ABORT), 1'b0});
    bus.rst_cmd(1'b0);
    chk({flash_mode, read_mode}, 4'h1);
    $display("program and error done");
    // sector erase aborted by reset command
    pulse(6'h10);
    bus.rst_cmd(1'b1);
    chk(flash_mode, FL_RECOVER);
    chk(small_mode, FL_RECOVER);
    wait_mode(FL_READ, 40);
    chk(n, ABORT);
    $display("sector abort done");
    // bulk erase: reset ignored, pin aborts
    pulse(6'h08);
    chk(erase_sector_mask, {~sl, ~ml});
    bus.rst_cmd(1'b1);
    chk(flash_mode, FL_BULK);
    pulse(6'h02);
    chk(error_status_bit, 1'b1);
    @(posedge ref_clk);
    reset_pin_n <= 1'b0; // held past the abort span
    wait_mode(FL_RECOVER, 10);
    chk(flash_mode, FL_RECOVER);
    wait_mode(FL_READ, 40);
    chk({31'(n), error_status_bit}, {31'(ABORT), 1'b0});
    @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    $display("pin abort done");
    // sram enable follows select, battery indicator
    for (int j = 0; j < 20; j++)
    begin
      lf = lfsr(lf);
      @(posedge ref_clk);
      sram_select <= lf[0];
      q.push_back(lf[0]);
      #1;
      if (q.size() == 2)
        chk(sram_enable, q.pop_front());
    end
    @(posedge ref_clk);
    battery_ind_enable <= 1'b1;
    supply_below_battery <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(battery_active, 1'b1);
    @(posedge ref_clk);
    battery_ind_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(battery_active, 1'b0);
    @(posedge ref_clk);
    battery_ind_enable <= 1'b1;
    supply_below_battery <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(battery_active, 1'b0);
    $display("sram and battery done");
    results();
  end
endmodule : flash_sector_protect_and_reset_tb
